/* rtl/lsrsr_display_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// Operation
// - source priority: segments, host value, held value, peak, live result
// - overrange flag latches when result exceeds the signed upper limit
// - upper limit resets to 7cf0 (3.5 digit) or 4e1f (4.5 digit)
// - overrange shows leading 1 plus four or three dashes
// - underrange flag latches when result falls below signed lower limit
// - lower limit resets to 8300 (3.5 digit) or b1e0 (4.5 digit)
// - underrange shows leading -1 plus four or three dashes
// - both limits compare as signed 16-bit two's complement
// - segment registers drive the display only while direct select is set
// - segment bits active low; zero lights the segment
// - first segment register layout, digit 2 and 1 plus custom annunciator
// - second segment register layout, digit 4, minus, digit 3, low supply
// - third segment register: peak, hold, leading one, digit 4 b c a g d
// - digit 4 bits act only on the 4.5 digit variant
// - leading one bit drives fifth or fourth position by variant
// - result is calibrated input minus signed offset register, reset zero
// - range flags stay until status read, and survive while still true
// - hold freezes the shown value while conversions go on
// - peak keeps the largest result; clearing peak clears the register
module lsrsr_display_regs
#(
  parameter bit FOUR_AND_HALF = 1'b1
)
(
  input  wire logic                               i_clock,
  input  wire logic                               i_reset,
  input  wire logic                               i_reg_write,
  input  wire logic                               i_reg_read,
  input  wire logic [4:0]                         i_reg_address,
  input  wire logic [15:0]                        i_reg_write_data,
  output var  logic [15:0]                        o_reg_read_data,
  output var  logic                               o_reg_read_valid,
  input  wire logic                               i_conversion_valid,
  input  wire logic [19:0]                        i_conversion_data,
  input  wire logic                               i_low_supply_pin,
  output var  lsrsr_pkg::lsrsr_mode_type          o_display_mode,
  output var  logic [15:0]                        o_display_value,
  output var  logic [2:0]                         o_dash_count,
  output var  logic [lsrsr_pkg::SEGMENT_WIDTH-1:0] o_segment_on,
  output var  logic                               o_lead_one_fifth,
  output var  logic                               o_lead_one_fourth
);
  import lsrsr_pkg::*;

  // =====================================================================
  // state
  typedef struct packed {
    logic [15:0]                control;
    logic [15:0]                over_limit;
    logic [15:0]                under_limit;
    logic [15:0]                seg_first;
    logic [15:0]                seg_second;
    logic [7:0]                 seg_third;
    logic [15:0]                offset;
    logic [15:0]                result_high;
    logic [3:0]                 result_low;
    logic [15:0]                lcd_data;
    logic [15:0]                peak;
    logic                       peak_armed;
    logic                       sign_flag;
    logic                       over_flag;
    logic                       under_flag;
    logic                       low_flag;
    logic                       ready_flag;
    logic                       sign_now;
    logic                       over_now;
    logic                       under_now;
    logic [2:0]                 low_sync;
    logic                       low_level;
    logic [15:0]                read_data;
    logic                       read_valid;
    lsrsr_mode_type             mode;
    logic [15:0]                display_value;
    logic [2:0]                 dash_count;
    logic [SEGMENT_WIDTH-1:0]   segment_on;
    logic                       lead_fifth;
    logic                       lead_fourth;
  } lsrsr_state_type;

  localparam logic [15:0] OVER_RESET =
    FOUR_AND_HALF ? OVER_LIMIT_RESET_4 : OVER_LIMIT_RESET_3;
  localparam logic [15:0] UNDERRANGE_FLAG_RESET =
    FOUR_AND_HALF ? UNDERRANGE_FLAG_LIMIT_RESET_4 : UNDERRANGE_FLAG_LIMIT_RESET_3;
  localparam logic [2:0] DASHES =
    FOUR_AND_HALF ? DASH_COUNT_4 : DASH_COUNT_3;

  localparam lsrsr_state_type RESET_STATE = '{
    over_limit  : OVER_RESET,
    under_limit : UNDERRANGE_FLAG_RESET,
    offset      : RESET_ZERO16,
    seg_third   : RESET_ZERO8,
    mode        : LSRSR_MODE_NUMERIC,
    dash_count  : DASHES,
    default     : '0
  };

  lsrsr_state_type          state;
  lsrsr_state_type          next_state;
  lsrsr_state_type          written;
  logic [19:0]              adjusted;
  logic                     range_over;
  logic                     range_under;
  logic [SEGMENT_WIDTH-1:0] map_segment_on;
  logic                     map_lead_fifth;
  logic                     map_lead_fourth;

  // =====================================================================
  // read decode; unmapped addresses read back as zero
  function automatic logic [15:0] read_value(
    input lsrsr_state_type s,
    input logic [4:0]      address
  );
    logic [15:0] value;
    value = 16'h0000;
    unique case (address)
      ADDR_STATUS:
        value = {8'h00, s.sign_flag, s.over_flag, s.under_flag,
                 s.low_flag, s.ready_flag, 3'h0};
      ADDR_CONTROL:     value = s.control;
      ADDR_OVER_LIMIT:  value = s.over_limit;
      ADDR_UNDER_LIMIT: value = s.under_limit;
      ADDR_SEG_FIRST:   value = s.seg_first;
      ADDR_SEG_SECOND:  value = s.seg_second;
      ADDR_SEG_THIRD:   value = {8'h00, s.seg_third};
      ADDR_OFFSET:      value = s.offset;
      ADDR_RESULT_HIGH: value = s.result_high;
      ADDR_LCD_DATA:    value = s.lcd_data;
      ADDR_PEAK:        value = s.peak;
      ADDR_RESULT_LOW:  value = {8'h00, s.result_low, 4'h0};
      default:          value = 16'h0000;
    endcase
    return value;
  endfunction

  // =====================================================================
  // host write decode; read-only addresses drop the write
  // kept out of the main process so that the segment map, which must see
  // a write in the cycle it lands, reads nothing of its own making
  function automatic lsrsr_state_type apply_write(
    input lsrsr_state_type s,
    input logic            write,
    input logic [4:0]      address,
    input logic [15:0]     data
  );
    lsrsr_state_type w;
    w = s;
    if (write)
    begin
      unique case (address)
        ADDR_CONTROL:
          w.control     = data & CTRL_WRITE_MASK;
        ADDR_OVER_LIMIT:
          w.over_limit  = data;
        ADDR_UNDER_LIMIT:
          w.under_limit = data;
        ADDR_SEG_FIRST:
          w.seg_first   = {data[15:1], 1'b0};
        ADDR_SEG_SECOND:
          w.seg_second  = {data[15:1], 1'b0};
        ADDR_SEG_THIRD:
          w.seg_third   = data[7:0];
        ADDR_OFFSET:
          w.offset      = data;
        ADDR_LCD_DATA:
          w.lcd_data    = data;
        default:
          w.control     = s.control;
      endcase
    end
    return w;
  endfunction

  // =====================================================================
  // display source; segments beat the range dashes, over beats under
  function automatic lsrsr_mode_type pick_mode(
    input logic select,
    input logic over,
    input logic under
  );
    lsrsr_mode_type m;
    if (select)
      m = LSRSR_MODE_SEGMENTS;
    else if (over)
      m = LSRSR_MODE_OVER;
    else if (under)
      m = LSRSR_MODE_UNDER;
    else
      m = LSRSR_MODE_NUMERIC;
    return m;
  endfunction

  // =====================================================================
  // offset removal and the two helpers
  // offset sits on the 16 upper bits of the 20-bit calibrated word
  assign adjusted = i_conversion_data - {state.offset, 4'h0};
  assign written  = apply_write(state, i_reg_write, i_reg_address,
                                i_reg_write_data);

  lsrsr_range_check u_range_check
  (
    .i_result      (adjusted[19:4]),
    .i_over_limit  (state.over_limit),
    .i_under_limit (state.under_limit),
    .o_over        (range_over),
    .o_under       (range_under)
  );

  lsrsr_segment_map #(
    .FOUR_AND_HALF (FOUR_AND_HALF)
  ) u_segment_map
  (
    .i_select          (written.control[CTRL_SEGMENT_SEL]),
    .i_seg_first       (written.seg_first),
    .i_seg_second      (written.seg_second),
    .i_seg_third       (written.seg_third),
    .o_segment_on      (map_segment_on),
    .o_lead_one_fifth  (map_lead_fifth),
    .o_lead_one_fourth (map_lead_fourth)
  );

  // =====================================================================
  // next state
  always_comb
  begin
    next_state            = written;
    next_state.read_valid = 1'b0;

    // low supply pin: first stage only feeds the second
    next_state.low_sync = {state.low_sync[1:0], i_low_supply_pin};
    if (state.low_sync[1] == state.low_sync[2])
      next_state.low_level = state.low_sync[2];

    // register reads; a status read clears flags whose cause is gone
    if (i_reg_read)
    begin
      next_state.read_valid = 1'b1;
      next_state.read_data  = read_value(state, i_reg_address);
      if (i_reg_address == ADDR_STATUS)
      begin
        next_state.sign_flag  = state.sign_now;
        next_state.over_flag  = state.over_now;
        next_state.under_flag = state.under_now;
        next_state.low_flag   = state.low_level;
      end
      if (i_reg_address == ADDR_RESULT_HIGH)
        next_state.ready_flag = 1'b0;
    end

    // low supply keeps its flag set, winning over a clear
    if (state.low_level)
      next_state.low_flag = 1'b1;

    // peak off empties the register and disarms the first capture
    if (!next_state.control[CTRL_PEAK])
    begin
      next_state.peak       = RESET_ZERO16;
      next_state.peak_armed = 1'b0;
    end

    // one evaluation per finished conversion; sets beat clears
    if (i_conversion_valid)
    begin
      next_state.result_high = adjusted[19:4];
      next_state.result_low  = adjusted[3:0];
      next_state.ready_flag  = 1'b1;
      next_state.sign_now    = adjusted[19];
      next_state.over_now    = range_over;
      next_state.under_now   = range_under;
      if (adjusted[19])
        next_state.sign_flag = 1'b1;
      if (range_over)
        next_state.over_flag = 1'b1;
      if (range_under)
        next_state.under_flag = 1'b1;
      if (next_state.control[CTRL_PEAK])
      begin
        if (!state.peak_armed ||
            $signed(adjusted[19:4]) > $signed(state.peak))
          next_state.peak = adjusted[19:4];
        next_state.peak_armed = 1'b1;
      end
      // held or host-owned data register stays as it is
      if (!next_state.control[CTRL_HOST_SOURCE] &&
          !next_state.control[CTRL_HOLD])
        next_state.lcd_data = next_state.control[CTRL_PEAK] ?
                              next_state.peak : adjusted[19:4];
    end

    // display source; the data register already carries the priority
    next_state.display_value = next_state.lcd_data;
    next_state.dash_count    = DASHES;
    next_state.segment_on    = map_segment_on;
    next_state.lead_fifth    = map_lead_fifth;
    next_state.lead_fourth   = map_lead_fourth;
    next_state.mode = pick_mode(next_state.control[CTRL_SEGMENT_SEL],
                                next_state.over_flag,
                                next_state.under_flag);
  end

  // =====================================================================
  // state register
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      state <= RESET_STATE;
    else
      state <= next_state;
  end

  // =====================================================================
  // outputs, all from the state register
  assign o_reg_read_data   = state.read_data;
  assign o_reg_read_valid  = state.read_valid;
  assign o_display_mode    = state.mode;
  assign o_display_value   = state.display_value;
  assign o_dash_count      = state.dash_count;
  assign o_segment_on      = state.segment_on;
  assign o_lead_one_fifth  = state.lead_fifth;
  assign o_lead_one_fourth = state.lead_fourth;

endmodule // lsrsr_display_regs
`default_nettype wire

/* rtl/lsrsr_pkg.sv */
`default_nettype none
package lsrsr_pkg;

  // =====================================================================
  // register addresses
  localparam logic [4:0] ADDR_STATUS       = 5'h00;
  localparam logic [4:0] ADDR_CONTROL      = 5'h01;
  localparam logic [4:0] ADDR_OVER_LIMIT   = 5'h02;
  localparam logic [4:0] ADDR_UNDER_LIMIT  = 5'h03;
  localparam logic [4:0] ADDR_SEG_FIRST    = 5'h04;
  localparam logic [4:0] ADDR_SEG_SECOND   = 5'h05;
  localparam logic [4:0] ADDR_SEG_THIRD    = 5'h06;
  localparam logic [4:0] ADDR_OFFSET       = 5'h07;
  localparam logic [4:0] ADDR_RESULT_HIGH  = 5'h08;
  localparam logic [4:0] ADDR_LCD_DATA     = 5'h09;
  localparam logic [4:0] ADDR_PEAK         = 5'h0a;
  localparam logic [4:0] ADDR_RESULT_LOW   = 5'h14;

  // =====================================================================
  // control field positions
  localparam int CTRL_HOST_SOURCE  = 15;
  localparam int CTRL_HOLD         = 7;
  localparam int CTRL_PEAK         = 6;
  localparam int CTRL_SEGMENT_SEL  = 3;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'hfffe;

  // =====================================================================
  // status field positions
  localparam int STAT_SIGN  = 7;
  localparam int STAT_OVER  = 6;
  localparam int STAT_UNDER = 5;
  localparam int STAT_LOW   = 4;
  localparam int STAT_READY = 3;

  // =====================================================================
  // reset values
  localparam logic [15:0] RESET_ZERO16       = 16'h0000;
  localparam logic [7:0]  RESET_ZERO8        = 8'h00;
  localparam logic [15:0] OVER_LIMIT_RESET_3 = 16'h7cf0;
  localparam logic [15:0] OVER_LIMIT_RESET_4 = 16'h4e1f;
  localparam logic [15:0] UNDERRANGE_FLAG_LIMIT_RESET_3 = 16'h8300;
  localparam logic [15:0] UNDERRANGE_FLAG_LIMIT_RESET_4 = 16'hb1e0;

  // =====================================================================
  // display
  localparam logic [2:0] DASH_COUNT_3 = 3'h3;
  localparam logic [2:0] DASH_COUNT_4 = 3'h4;
  localparam int SEGMENT_WIDTH = 38;
  localparam int SEG2_DIGIT4_TOP = 15;
  localparam int SEG2_DIGIT4_LOW = 13;
  localparam int SEG3_LEAD_ONE   = 5;
  localparam int SEG3_DIGIT4_TOP = 4;

  typedef enum logic [3:0] {
    LSRSR_MODE_NUMERIC  = 4'b0001,
    LSRSR_MODE_SEGMENTS = 4'b0010,
    LSRSR_MODE_OVER     = 4'b0100,
    LSRSR_MODE_UNDER    = 4'b1000
  } lsrsr_mode_type;

endpackage
`default_nettype wire

/* rtl/lsrsr_range_check.sv */
`timescale 1ns/1ns
`default_nettype none
module lsrsr_range_check
(
  input  wire logic [15:0] i_result,
  input  wire logic [15:0] i_over_limit,
  input  wire logic [15:0] i_under_limit,
  output var  logic        o_over,
  output var  logic        o_under
);
  import lsrsr_pkg::*;

  // =====================================================================
  // signed compare against both limits
  always_comb
  begin
    o_over  = $signed(i_result) > $signed(i_over_limit);
    o_under = $signed(i_result) < $signed(i_under_limit);
  end

endmodule // lsrsr_range_check
`default_nettype wire

/* rtl/lsrsr_segment_map.sv */
`timescale 1ns/1ns
`default_nettype none
module lsrsr_segment_map
#(
  parameter bit FOUR_AND_HALF = 1'b1
)
(
  input  wire logic                     i_select,
  input  wire logic [15:0]              i_seg_first,
  input  wire logic [15:0]              i_seg_second,
  input  wire logic [7:0]               i_seg_third,
  output var  logic [lsrsr_pkg::SEGMENT_WIDTH-1:0] o_segment_on,
  output var  logic                     o_lead_one_fifth,
  output var  logic                     o_lead_one_fourth
);
  import lsrsr_pkg::*;

  logic [15:0] second_view;
  logic [7:0]  third_view;

  // =====================================================================
  // active-low bits, digit 4 dropped on the short variant
  always_comb
  begin
    second_view = i_seg_second;
    third_view  = i_seg_third;
    if (!FOUR_AND_HALF)
    begin
      second_view[SEG2_DIGIT4_TOP:SEG2_DIGIT4_LOW] = 3'h7;
      third_view[SEG3_DIGIT4_TOP:0]                = 5'h1f;
    end
    o_segment_on      = '0;
    o_lead_one_fifth  = 1'b0;
    o_lead_one_fourth = 1'b0;
    if (i_select)
    begin
      // bit 0 of the wide registers is always zero and carries nothing
      o_segment_on = ~{i_seg_first[15:1], second_view[15:1],
                       third_view};
      if (FOUR_AND_HALF)
        o_lead_one_fifth  = ~i_seg_third[SEG3_LEAD_ONE];
      else
        o_lead_one_fourth = ~i_seg_third[SEG3_LEAD_ONE];
    end
  end

endmodule // lsrsr_segment_map
`default_nettype wire

/* verification/lsrsr_display_regs_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module lsrsr_display_regs_monitor
  import lsrsr_pkg::*;
#(
  parameter bit FOUR_AND_HALF = 1'b1
)
(
  input wire logic                        i_clock,
  input wire logic                        i_reset,
  input wire logic                        i_reg_write,
  input wire logic                        i_reg_read,
  input wire logic [4:0]                  i_reg_address,
  input wire logic [15:0]                 i_reg_write_data,
  input wire logic [15:0]                 o_reg_read_data,
  input wire logic                        o_reg_read_valid,
  input wire logic                        i_conversion_valid,
  input wire logic [19:0]                 i_conversion_data,
  input wire logic                        i_low_supply_pin,
  input wire lsrsr_pkg::lsrsr_mode_type   o_display_mode,
  input wire logic [15:0]                 o_display_value,
  input wire logic [2:0]                  o_dash_count,
  input wire logic [SEGMENT_WIDTH-1:0]    o_segment_on,
  input wire logic                        o_lead_one_fifth,
  input wire logic                        o_lead_one_fourth
);
  // ==========
  // shadow copies of host-written registers
  logic [15:0] ctrl;
  logic [15:0] offs;
  logic [15:0] over_lim;
  logic [15:0] underrange_flag_lim;
  logic [15:0] seg1;
  logic [19:0] res;
  assign res = i_conversion_data - {offs, 4'h0};
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      ctrl <= 16'h0000;
      offs <= 16'h0000;
      seg1 <= 16'h0000;
      over_lim <= FOUR_AND_HALF ? OVER_LIMIT_RESET_4 : OVER_LIMIT_RESET_3;
      underrange_flag_lim <= FOUR_AND_HALF ? UNDERRANGE_FLAG_LIMIT_RESET_4 : UNDERRANGE_FLAG_LIMIT_RESET_3;
    end
    else if (i_reg_write)
    begin
      case (i_reg_address)
        ADDR_CONTROL: ctrl <= i_reg_write_data & CTRL_WRITE_MASK;
        ADDR_OFFSET: offs <= i_reg_write_data;
        ADDR_SEG_FIRST: seg1 <= i_reg_write_data;
        ADDR_OVER_LIMIT: over_lim <= i_reg_write_data;
        ADDR_UNDER_LIMIT: underrange_flag_lim <= i_reg_write_data;
        default: ;
      endcase
    end
  end
  // ==========
  // assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_source_onehot: assert property (
    $onehot(o_display_mode)) else $error("display mode not one-hot");
  a_select_segments: assert property (
    ctrl[CTRL_SEGMENT_SEL] |-> o_display_mode == LSRSR_MODE_SEGMENTS)
    else $error("segment select not shown");
  a_over_shown: assert property (
    i_conversion_valid && !i_reg_write && !ctrl[CTRL_SEGMENT_SEL] &&
    $signed(res[19:4]) > $signed(over_lim)
    |=> o_display_mode == LSRSR_MODE_OVER) else $error("overrange missed");
  a_under_shown: assert property (
    i_conversion_valid && !i_reg_write && !ctrl[CTRL_SEGMENT_SEL] &&
    $signed(res[19:4]) < $signed(underrange_flag_lim)
    |=> o_display_mode inside {LSRSR_MODE_UNDER, LSRSR_MODE_OVER})
    else $error("underrange missed");
  a_dash_count: assert property (
    o_dash_count == (FOUR_AND_HALF ? DASH_COUNT_4 : DASH_COUNT_3))
    else $error("wrong dash count");
  a_segments_gated: assert property (
    o_display_mode != LSRSR_MODE_SEGMENTS |-> o_segment_on == '0 &&
    !o_lead_one_fifth && !o_lead_one_fourth) else $error("segments leak");
  a_segment_first: assert property (
    o_display_mode == LSRSR_MODE_SEGMENTS |-> o_segment_on[37:23] ==
    ~seg1[15:1]) else $error("first segment map wrong");
  a_lead_one_pos: assert property (
    FOUR_AND_HALF ? !o_lead_one_fourth : !o_lead_one_fifth)
    else $error("leading one on wrong digit");
  a_hold_freeze: assert property (
    i_conversion_valid && ctrl[CTRL_HOLD] && !ctrl[CTRL_HOST_SOURCE] &&
    !i_reg_write |=> $stable(o_display_value)) else $error("hold moved");
  a_read_answer: assert property (
    i_reg_read |=> o_reg_read_valid) else $error("read not answered");
endmodule // lsrsr_display_regs_monitor
bind lsrsr_display_regs lsrsr_display_regs_monitor
  #(.FOUR_AND_HALF(FOUR_AND_HALF)) i_monitor (.i_clock(i_clock),
  .i_reset(i_reset), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
  .i_reg_address(i_reg_address), .i_reg_write_data(i_reg_write_data),
  .o_reg_read_data(o_reg_read_data), .o_reg_read_valid(o_reg_read_valid),
  .i_conversion_valid(i_conversion_valid),
  .i_conversion_data(i_conversion_data),
  .i_low_supply_pin(i_low_supply_pin), .o_display_mode(o_display_mode),
  .o_display_value(o_display_value), .o_dash_count(o_dash_count),
  .o_segment_on(o_segment_on), .o_lead_one_fifth(o_lead_one_fifth),
  .o_lead_one_fourth(o_lead_one_fourth));
`default_nettype wire

/* verification/lsrsr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lsrsr_host_model
(
  input  wire logic        i_clock,
  input  wire logic        i_read_valid,
  input  wire logic [15:0] i_read_data,
  output var  logic        o_write,
  output var  logic        o_read,
  output var  logic [4:0]  o_address,
  output var  logic [15:0] o_write_data
);
  // ==========
  // register access, one strobe cycle per access
  initial
  begin
    o_write = 1'b0;
    o_read = 1'b0;
    o_address = 5'h00;
    o_write_data = 16'h0000;
  end
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clock);
    o_write <= 1'b1;
    o_address <= a;
    o_write_data <= d;
    @(posedge i_clock);
    o_write <= 1'b0;
    o_write_data <= ~d; // stale data never looks valid
  endtask
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    o_read <= 1'b1;
    o_address <= a;
    @(posedge i_clock);
    o_read <= 1'b0;
    #1;
    while (i_read_valid !== 1'b1 && n < 4)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
    d = (n < 4) ? i_read_data : 16'hxxxx;
  endtask
endmodule // lsrsr_host_model
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lsrsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr, rdn, cv = 1'b0, rv;
  logic [4:0] adr;
  logic [15:0] wd, rdat, value, rdat_s;
  logic [19:0] cd = 20'h00000;
  lsrsr_mode_type mode, mode_s;
  logic [2:0] dash, dash_s;
  logic [SEGMENT_WIDTH-1:0] seg, seg_s;
  logic lead5, lead4, lead5_s, lead4_s;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  lsrsr_host_model i_lsrsr_host_model (.i_clock(clk), .i_read_valid(rv),
    .i_read_data(rdat), .o_write(wr), .o_read(rdn), .o_address(adr),
    .o_write_data(wd));
  lsrsr_display_regs #(.FOUR_AND_HALF(1'b1)) i_lsrsr_display_regs (
    .i_clock(clk), .i_reset(rst), .i_reg_write(wr), .i_reg_read(rdn),
    .i_reg_address(adr), .i_reg_write_data(wd), .o_reg_read_data(rdat),
    .o_reg_read_valid(rv), .i_conversion_valid(cv),
    .i_conversion_data(cd), .i_low_supply_pin(1'b0),
    .o_display_mode(mode), .o_display_value(value), .o_dash_count(dash),
    .o_segment_on(seg), .o_lead_one_fifth(lead5), .o_lead_one_fourth(lead4));
  // 3.5 digit copy on the same bus and conversion feed
  lsrsr_display_regs #(.FOUR_AND_HALF(1'b0)) i_lsrsr_display_regs_short (
    .i_clock(clk), .i_reset(rst), .i_reg_write(wr), .i_reg_read(rdn),
    .i_reg_address(adr), .i_reg_write_data(wd), .o_reg_read_data(rdat_s),
    .o_reg_read_valid(), .i_conversion_valid(cv),
    .i_conversion_data(cd), .i_low_supply_pin(1'b0),
    .o_display_mode(mode_s), .o_display_value(), .o_dash_count(dash_s),
    .o_segment_on(seg_s), .o_lead_one_fifth(lead5_s),
    .o_lead_one_fourth(lead4_s));
  // ==========
  // helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [4:0] a, input logic [15:0] d);
    i_lsrsr_host_model.write_reg(a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_lsrsr_host_model.read_reg(a, d);
    chk(38'(d), 38'(exp));
  endtask
  task automatic conv(input logic [15:0] hi);
    @(posedge clk);
    cv <= 1'b1;
    cd <= {hi, 4'h0};
    @(posedge clk);
    cv <= 1'b0;
    cd <= ~{hi, 4'h0};
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ==========
  // hang guard, the sequence needs well under 1000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  // ==========
  // tests
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_OVER_LIMIT, OVER_LIMIT_RESET_4);
    chk(38'(rdat_s), 38'(OVER_LIMIT_RESET_3));
    rd(ADDR_UNDER_LIMIT, UNDERRANGE_FLAG_LIMIT_RESET_4);
    chk(38'(rdat_s), 38'(UNDERRANGE_FLAG_LIMIT_RESET_3));
    rd(ADDR_SEG_FIRST, RESET_ZERO16);
    rd(ADDR_SEG_SECOND, RESET_ZERO16);
    rd(ADDR_SEG_THIRD, RESET_ZERO16);
    rd(ADDR_OFFSET, RESET_ZERO16);
    rd(5'h1f, 16'h0000);
    wrt(ADDR_SEG_THIRD, 16'hffff);
    rd(ADDR_SEG_THIRD, 16'h00ff);
    wrt(ADDR_SEG_FIRST, 16'hffff);
    rd(ADDR_SEG_FIRST, 16'hfffe);
    $display("test registers done");
    wrt(ADDR_OFFSET, 16'h0010);
    conv(16'h0133);
    rd(ADDR_RESULT_HIGH, 16'h0123);
    chk(38'(value), 38'h0123);
    conv(16'h4e2f);
    chk(38'(mode), 38'(LSRSR_MODE_NUMERIC));
    conv(16'h4e30);
    chk(38'(mode), 38'(LSRSR_MODE_OVER));
    chk(38'(dash), 38'(DASH_COUNT_4));
    chk(38'(dash_s), 38'(DASH_COUNT_3));
    wrt(ADDR_OFFSET, 16'h0000);
    rd(ADDR_STATUS, 16'h0048);
    conv(16'h0000);
    rd(ADDR_STATUS, 16'h0048);
    rd(ADDR_STATUS, 16'h0008);
    chk(38'(mode), 38'(LSRSR_MODE_NUMERIC));
    conv(16'h8000);
    chk(38'(mode), 38'(LSRSR_MODE_UNDER));
    chk(38'(mode_s), 38'(LSRSR_MODE_UNDER));
    conv(16'hb1e0);
    rd(ADDR_STATUS, 16'h00a8);
    rd(ADDR_STATUS, 16'h0088);
    $display("test range done");
    conv(16'h0200);
    chk(38'(value), 38'h0200);
    wrt(ADDR_CONTROL, 16'h0080);
    conv(16'h0300);
    chk(38'(value), 38'h0200);
    rd(ADDR_RESULT_HIGH, 16'h0300);
    wrt(ADDR_CONTROL, 16'h8080);
    wrt(ADDR_LCD_DATA, 16'h5555);
    conv(16'h0400);
    chk(38'(value), 38'h5555);
    wrt(ADDR_CONTROL, 16'h0040);
    conv(16'h0100);
    conv(16'h0300);
    conv(16'hff00);
    chk(38'(value), 38'h0300);
    rd(ADDR_PEAK, 16'h0300);
    wrt(ADDR_CONTROL, 16'h0000);
    rd(ADDR_PEAK, 16'h0000);
    $display("test source done");
    wrt(ADDR_SEG_FIRST, 16'h00ff);
    wrt(ADDR_SEG_SECOND, 16'h1fff);
    wrt(ADDR_SEG_THIRD, 16'h0000);
    wrt(ADDR_CONTROL, 16'h8008);
    @(posedge clk);
    #1;
    chk(38'(mode), 38'(LSRSR_MODE_SEGMENTS));
    chk(seg, ~{15'h007f, 15'h0fff, 8'h00});
    chk(seg_s, ~{15'h007f, 15'h7fff, 8'h1f});
    chk(38'(lead5), 38'h1);
    chk(38'(lead4), 38'h0);
    chk(38'(lead5_s), 38'h0);
    chk(38'(lead4_s), 38'h1);
    wrt(ADDR_CONTROL, 16'h0000);
    @(posedge clk);
    #1;
    chk(seg, 38'h0);
    $display("test segments done");
    close_out();
  end
endmodule // tb
`default_nettype wire
